// ==== src/sppc_pkg.sv ====
// Shared constants and types for the single-pin configuration link
package sppc_pkg;
    // ==========================================================
    // Clock and bit timing
    localparam int CLK_MHZ = 250;
    localparam int BIT_KHZ = 70;
    localparam int BIT_CYC = CLK_MHZ * 1000 / BIT_KHZ;
    localparam int SHORT_CYC = BIT_CYC / 5;
    localparam int LONG_CYC = BIT_CYC * 4 / 5;
    localparam int SAMP_CYC = BIT_CYC / 2;
    localparam int TMO_MS = 16;
    localparam int TMO_CYC_DEF = TMO_MS * CLK_MHZ * 1000;
    localparam int EE_WAIT_MS = 10;
    localparam int EE_WAIT_CYC_DEF = EE_WAIT_MS * CLK_MHZ * 1000;
    localparam int T7_BITS = 3;
    localparam int T7_CYC_DEF =
        (T7_BITS * CLK_MHZ * 1000 + BIT_KHZ - 1) / BIT_KHZ;
    localparam int TMR_W = 22;
    // ==========================================================
    // Framing and command codes
    localparam int ENTRY_BITS = 6;
    localparam int FRAME_BITS = 11;
    localparam int WORD_W = 8;
    localparam int NUM_WORDS = 6;
    localparam int RB_BITS = 59;
    localparam int RB_EDGES = 60;
    localparam logic [5:0] CODE_PROG = 6'h0C;
    localparam logic [5:0] CODE_RB = 6'h3B;
    localparam logic [2:0] SEL_JUMP = 3'h7;
    localparam logic [7:0] JMP_FREE = 8'hF0;
    localparam logic [7:0] JMP_LOCK = 8'h55;
    localparam logic [7:0] WORD_RST = 8'h00;
    localparam int DRV_BIT = 1;
    // ==========================================================
    // State encodings
    typedef enum logic [4:0] {
        ST_NORMAL = 5'h01,
        ST_PROG = 5'h02,
        ST_EE_FREE = 5'h04,
        ST_EE_LOCK = 5'h08,
        ST_READBACK = 5'h10
    } sppc_state_t;
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_HIGH = 4'h2,
        H_LOW = 4'h4,
        H_GAP = 4'h8
    } sppc_hstate_t;
    localparam logic [1:0] KIND_ENTRY = 2'h0;
    localparam logic [1:0] KIND_FRAME = 2'h1;
    localparam logic [1:0] KIND_READ = 2'h2;
endpackage

// ==== src/sppc_link_if.sv ====
// Single-pin link wires between the programmer and the device
`timescale 1ns/100ps
interface sppc_link_if;
    logic serial_program_pin;
    logic ce;
    logic fout;
    modport dev (input serial_program_pin, input ce, output fout);
    modport host (output serial_program_pin, output ce, input fout);
endinterface

// ==== src/sppc_bit_rx.sv ====
// Pulse-width bit decoder with edge and phase time-out detection
`timescale 1ns/100ps
module sppc_bit_rx
    import sppc_pkg::*;
#(
    parameter int TMO_CYC = TMO_CYC_DEF
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic pin,
    output logic rise,
    output logic bit_vld,
    output logic bit_val,
    output logic tmo
);
    logic meta_q;
    logic pin_q;
    logic prev_q;
    logic run_q;
    logic [11:0] dly_q;
    logic [TMR_W-1:0] phase_q;
    logic delayed_program_sample;

    // ==========================================================
    // Synchroniser
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= 1'b0;
            pin_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= pin;
            pin_q <= meta_q;
            prev_q <= pin_q;
        end
    end

    assign rise = pin_q & ~prev_q;

    // ==========================================================
    // Delayed strobe samples the live pin
    // Half a period sits between short and long highs at any legal rate
    assign delayed_program_sample = run_q && dly_q == 12'(SAMP_CYC);
    assign bit_vld = delayed_program_sample;
    assign bit_val = pin_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            run_q <= 1'b0;
            dly_q <= 12'h000;
        end
        else if (rise)
        begin
            run_q <= 1'b1;
            dly_q <= 12'h001;
        end
        else if (delayed_program_sample)
        begin
            run_q <= 1'b0;
        end
        else if (run_q)
        begin
            dly_q <= dly_q + 12'h001;
        end
    end

    // ==========================================================
    // Per-phase time-out, restarted on every edge
    assign tmo = phase_q == TMR_W'(TMO_CYC - 1);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            phase_q <= '0;
        else if (pin_q != prev_q)
            phase_q <= '0;
        else if (phase_q != TMR_W'(TMO_CYC))
            phase_q <= phase_q + TMR_W'(1);
    end
endmodule

// ==== src/sppc_dev_end.sv ====
// Device end: command state machine, word registers, readback
//
// How it works
// - Configuration only enters through the program pin
// - Short high means 0, long high 1
// - Host low phase complements the high phase
// - Host bit rate 60 to 80 kHz
// - Delayed copy strobes the live pin
// - One bit per rising edge; gaps harmless outside normal
// - 001100 in normal enters programming
// - 111011 enters readback, same strict timing
// - Entry phase of 16 ms aborts sequence
// - Selector picks configuration word zero to five
// - Word latched and live after eleventh bit
// - Jump F0 enters unlocked EEPROM programming
// - Jump 55 enters locked EEPROM programming
// - Jump 00 leaves EEPROM programming to normal
// - Other jump codes exit to normal
// - Chip enable ignored in configuration states
// - Host holds enable three periods first
// - Exactly one driver selected, other off
// - Enable low in normal disables both drivers
// - Host waits 10 ms in EEPROM states
// - Readback: load edge puts out bit 0, 59 bits over 60 edges
`timescale 1ns/100ps
module sppc_dev_end
    import sppc_pkg::*;
#(
    parameter int TMO_CYC = TMO_CYC_DEF
)
(
    input wire logic CORE_CLK,
    input wire logic RSTN,
    sppc_link_if.dev LINK,
    input wire logic [RB_BITS-1:0] RB_IMAGE,
    output logic [NUM_WORDS*WORD_W-1:0] CFG_WORDS,
    output logic [4:0] STATE,
    output logic POWER_ON,
    output logic PECL_EN,
    output logic LVDS_EN
);
    sppc_state_t state_q;
    sppc_state_t state_d;
    logic rise;
    logic bit_vld;
    logic bit_val;
    logic tmo;
    logic ce_meta_q;
    logic ce_q;
    logic [FRAME_BITS-1:0] frame_q;
    logic [FRAME_BITS-1:0] frame_d;
    logic [3:0] cnt_q;
    logic entry_done;
    logic frame_done;
    logic is_jump;
    logic [WORD_W-1:0] words_q [NUM_WORDS];
    logic [RB_BITS-1:0] rb_sh_q;
    logic [5:0] rb_cnt_q;
    logic fout_q;
    logic pwr_d;

    // First selector bit on the pin is the word index's low bit
    function automatic logic [2:0] sel_idx(input logic [2:0] s);
        sel_idx = {s[0], s[1], s[2]};
    endfunction

    // ==========================================================
    // Bit decoder
    sppc_bit_rx #(
        .TMO_CYC(TMO_CYC)
    ) u_rx (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .pin(LINK.serial_program_pin),
        .rise(rise),
        .bit_vld(bit_vld),
        .bit_val(bit_val),
        .tmo(tmo)
    );

    // ==========================================================
    // Enable synchroniser
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ce_meta_q <= 1'b0;
            ce_q <= 1'b0;
        end
        else
        begin
            ce_meta_q <= LINK.ce;
            ce_q <= ce_meta_q;
        end
    end

    // ==========================================================
    // Command decode
    assign frame_d = {frame_q[FRAME_BITS-2:0], bit_val};
    assign entry_done = state_q == ST_NORMAL && bit_vld
        && cnt_q == 4'(ENTRY_BITS - 1);
    assign frame_done = (state_q == ST_PROG || state_q == ST_EE_FREE
        || state_q == ST_EE_LOCK) && bit_vld
        && cnt_q == 4'(FRAME_BITS - 1);
    assign is_jump = frame_d[FRAME_BITS-1:WORD_W] == SEL_JUMP;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_NORMAL:
            begin
                if (entry_done && frame_d[5:0] == CODE_PROG)
                    state_d = ST_PROG;
                else if (entry_done && frame_d[5:0] == CODE_RB)
                    state_d = ST_READBACK;
            end
            ST_PROG:
            begin
                if (frame_done && is_jump)
                begin
                    if (frame_d[WORD_W-1:0] == JMP_FREE)
                        state_d = ST_EE_FREE;
                    else if (frame_d[WORD_W-1:0] == JMP_LOCK)
                        state_d = ST_EE_LOCK;
                    else
                        state_d = ST_NORMAL;
                end
            end
            ST_EE_FREE, ST_EE_LOCK:
            begin
                // Exit code and any other jump both land in normal
                if (frame_done && is_jump)
                    state_d = ST_NORMAL;
            end
            ST_READBACK:
            begin
                if (rise && rb_cnt_q == 6'(RB_EDGES - 1))
                    state_d = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
            state_q <= ST_NORMAL;
        else
            state_q <= state_d;
    end

    // ==========================================================
    // Bit shifter and counter
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            frame_q <= '0;
            cnt_q <= 4'h0;
        end
        else if (state_d != state_q || entry_done || frame_done)
        begin
            frame_q <= '0;
            cnt_q <= 4'h0;
        end
        else if (state_q == ST_NORMAL && tmo)
        begin
            // Stalled entry sequence starts over from its first bit
            cnt_q <= 4'h0;
        end
        else if (bit_vld)
        begin
            frame_q <= frame_d;
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // ==========================================================
    // Configuration words, live as soon as latched
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            for (int i = 0; i < NUM_WORDS; i++)
                words_q[i] <= WORD_RST;
        end
        else if (state_q == ST_PROG && frame_done && !is_jump)
        begin
            for (int i = 0; i < NUM_WORDS; i++)
            begin
                if (sel_idx(frame_d[FRAME_BITS-1:WORD_W]) == 3'(i))
                    words_q[i] <= frame_d[WORD_W-1:0];
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < NUM_WORDS; i++)
            CFG_WORDS[i*WORD_W +: WORD_W] = words_q[i];
    end

    // ==========================================================
    // Readback shifter, pin acts as shift clock
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rb_sh_q <= '0;
            rb_cnt_q <= 6'h00;
            fout_q <= 1'b0;
        end
        else if (state_q != ST_READBACK)
        begin
            rb_cnt_q <= 6'h00;
            fout_q <= 1'b0;
        end
        else if (rise)
        begin
            rb_cnt_q <= rb_cnt_q + 6'h01;
            if (rb_cnt_q == 6'h00)
            begin
                rb_sh_q <= RB_IMAGE;
                fout_q <= RB_IMAGE[0];
            end
            else
            begin
                rb_sh_q <= {1'b0, rb_sh_q[RB_BITS-1:1]};
                fout_q <= rb_sh_q[1];
            end
        end
    end

    assign LINK.fout = fout_q;

    // ==========================================================
    // Power and driver select
    // Enable only counts in normal; config states stay powered
    assign pwr_d = state_q != ST_NORMAL || ce_q;

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            POWER_ON <= 1'b0;
            PECL_EN <= 1'b0;
            LVDS_EN <= 1'b0;
        end
        else
        begin
            POWER_ON <= pwr_d;
            PECL_EN <= pwr_d && words_q[0][DRV_BIT];
            LVDS_EN <= pwr_d && !words_q[0][DRV_BIT];
        end
    end

    assign STATE = state_q;
endmodule

// ==== src/sppc_host_end.sv ====
// Host end: pulse-width programmer for the single-pin link
`timescale 1ns/100ps
module sppc_host_end
    import sppc_pkg::*;
#(
    parameter int EE_WAIT_CYC = EE_WAIT_CYC_DEF,
    parameter int T7_CYC = T7_CYC_DEF
)
(
    input wire logic CORE_CLK,
    input wire logic RSTN,
    sppc_link_if.host LINK,
    input wire logic CHIP_EN,
    input wire logic CMD_VALID,
    input wire logic [1:0] CMD_KIND,
    input wire logic [FRAME_BITS-1:0] CMD_DATA,
    output logic CMD_READY,
    output logic [RB_BITS-1:0] RB_WORD,
    output logic RB_DONE
);
    sppc_hstate_t st_q;
    sppc_hstate_t st_d;
    logic accept;
    logic prog_q;
    logic ce_q;
    logic fo_meta_q;
    logic fo_q;
    logic [FRAME_BITS-1:0] bits_q;
    logic [5:0] left_q;
    logic [5:0] rb_idx_q;
    logic read_q;
    logic ee_q;
    logic [TMR_W-1:0] tim_q;
    logic [13:0] t7_q;
    logic hi_end;
    logic per_end;
    logic gap_end;
    logic ee_cmd;

    // High phase length for the bit at the front of the shifter
    function automatic logic [TMR_W-1:0] high_cyc(input logic b);
        high_cyc = b ? TMR_W'(LONG_CYC) : TMR_W'(SHORT_CYC);
    endfunction

    assign accept = CMD_VALID && CMD_READY;
    assign ee_cmd = CMD_KIND == KIND_FRAME
        && CMD_DATA[FRAME_BITS-1:WORD_W] == SEL_JUMP
        && (CMD_DATA[WORD_W-1:0] == JMP_FREE
        || CMD_DATA[WORD_W-1:0] == JMP_LOCK);
    // Period fixed at the nominal rate, well inside the legal window
    assign hi_end = tim_q
        == high_cyc(bits_q[FRAME_BITS-1]) - TMR_W'(1);
    // Low phase fills the rest, else the rate drops below the window
    assign per_end = tim_q == TMR_W'(BIT_CYC)
        - high_cyc(bits_q[FRAME_BITS-1]) - TMR_W'(1);
    assign gap_end = tim_q == TMR_W'(EE_WAIT_CYC - 1);

    // ==========================================================
    // Enable and readback pin synchroniser
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ce_q <= 1'b0;
            t7_q <= 14'h0000;
            fo_meta_q <= 1'b0;
            fo_q <= 1'b0;
        end
        else
        begin
            ce_q <= CHIP_EN;
            fo_meta_q <= LINK.fout;
            fo_q <= fo_meta_q;
            if (!ce_q)
                t7_q <= 14'h0000;
            else if (t7_q != 14'(T7_CYC))
                t7_q <= t7_q + 14'h0001;
        end
    end

    assign LINK.ce = ce_q;
    assign LINK.serial_program_pin = prog_q;

    // ==========================================================
    // Sequencer
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            H_IDLE:
                if (accept)
                    st_d = H_HIGH;
            H_HIGH:
                if (hi_end)
                    st_d = H_LOW;
            H_LOW:
            begin
                if (per_end && left_q != 6'h01)
                    st_d = H_HIGH;
                else if (per_end)
                    st_d = ee_q ? H_GAP : H_IDLE;
            end
            H_GAP:
                if (gap_end)
                    st_d = H_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            st_q <= H_IDLE;
            prog_q <= 1'b0;
            tim_q <= '0;
            CMD_READY <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            prog_q <= st_d == H_HIGH;
            tim_q <= st_d != st_q ? TMR_W'(0) : tim_q + TMR_W'(1);
            CMD_READY <= st_d == H_IDLE && !accept
                && t7_q == 14'(T7_CYC);
        end
    end

    // ==========================================================
    // Bit source and readback capture
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            bits_q <= '0;
            left_q <= 6'h00;
            read_q <= 1'b0;
            ee_q <= 1'b0;
            rb_idx_q <= 6'h00;
            RB_WORD <= '0;
            RB_DONE <= 1'b0;
        end
        else
        begin
            RB_DONE <= 1'b0;
            if (accept)
            begin
                read_q <= CMD_KIND == KIND_READ;
                ee_q <= ee_cmd;
                rb_idx_q <= 6'h00;
                unique case (CMD_KIND)
                    KIND_ENTRY:
                    begin
                        bits_q <= {CMD_DATA[ENTRY_BITS-1:0], 5'h00};
                        left_q <= 6'(ENTRY_BITS);
                    end
                    KIND_READ:
                    begin
                        bits_q <= '1;
                        left_q <= 6'(RB_EDGES);
                    end
                    default:
                    begin
                        bits_q <= CMD_DATA;
                        left_q <= 6'(FRAME_BITS);
                    end
                endcase
            end
            else if (st_q == H_LOW && per_end)
            begin
                bits_q <= {bits_q[FRAME_BITS-2:0], 1'b1};
                left_q <= left_q - 6'h01;
                if (read_q && rb_idx_q < 6'(RB_BITS))
                    RB_WORD[rb_idx_q] <= fo_q;
                rb_idx_q <= rb_idx_q + 6'h01;
                RB_DONE <= read_q && left_q == 6'h01;
            end
        end
    end
endmodule

// ==== sim/sppc_link_sva.sv ====
// Concurrent checks on the single-pin link between host and device ends
`timescale 1ns/100ps
module sppc_link_sva
    import sppc_pkg::*;
#(
    parameter int T7_CYC = T7_CYC_DEF
)
(
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic serial_program_pin,
    input wire logic ce,
    input wire logic fout
);
    // ==========================================================
    // Phase counters
    int hi_q;
    int lo_q;
    int per_q;
    int ce_q;
    int last_hi_q;

    always_ff @(posedge CORE_CLK or negedge RSTN)
        if (!RSTN)
            hi_q <= 0;
        else
            hi_q <= serial_program_pin ? hi_q + 1 : 0;

    always_ff @(posedge CORE_CLK or negedge RSTN)
        if (!RSTN)
            lo_q <= 0;
        else
            lo_q <= serial_program_pin ? 0 : lo_q + 1;

    // Starts at a full period so the first bit after reset is legal
    always_ff @(posedge CORE_CLK or negedge RSTN)
        if (!RSTN)
            per_q <= BIT_CYC;
        else
            per_q <= $rose(serial_program_pin) ? 1 : per_q + 1;

    always_ff @(posedge CORE_CLK or negedge RSTN)
        if (!RSTN)
            ce_q <= 0;
        else if (!ce)
            ce_q <= 0;
        else if (ce_q < T7_CYC)
            ce_q <= ce_q + 1;

    always_ff @(posedge CORE_CLK or negedge RSTN)
        if (!RSTN)
            last_hi_q <= 0;
        else if ($fell(serial_program_pin))
            last_hi_q <= hi_q;

    // ==========================================================
    // Assertions
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);

    sequence high_run;
        serial_program_pin[*8];
    endsequence

    a_high_width: assert property ($fell(serial_program_pin) |->
        (hi_q == SHORT_CYC || hi_q == LONG_CYC))
        else $error("high phase width is neither short nor long");
    // Counter bound, since the long width is far beyond a delay range
    a_fall_bound: assert property (hi_q <= LONG_CYC)
        else $error("high phase ran past the long width");
    a_high_min: assert property ($rose(serial_program_pin) |->
        high_run)
        else $error("high phase collapsed right after rising");
    a_low_zero: assert property ($rose(serial_program_pin) &&
        last_hi_q == SHORT_CYC |-> lo_q >= BIT_CYC - SHORT_CYC)
        else $error("low phase after a zero bit too short");
    a_low_one: assert property ($rose(serial_program_pin) &&
        last_hi_q == LONG_CYC |-> lo_q >= BIT_CYC - LONG_CYC)
        else $error("low phase after a one bit too short");
    a_bit_period: assert property ($rose(serial_program_pin) |->
        per_q >= BIT_CYC)
        else $error("bit period shorter than nominal");
    a_enable_lead: assert property ($rose(serial_program_pin) |->
        ce_q >= T7_CYC)
        else $error("pin rose too soon after enable");
    // Link under this checker never enters readback, so fout stays low
    a_fout_quiet: assert property ($rose(serial_program_pin) |->
        !fout throughout high_run)
        else $error("readback output moved outside readback");
endmodule

// ==== sim/tb.sv ====
// Testbench: host and device ends joined, plus a directly driven device
`timescale 1ns/100ps
module tb;
    import sppc_pkg::*;
    // ==========================================================
    // Signals and instances
    localparam int T7 = 50;
    localparam logic [RB_BITS-1:0] RB_PAT = 59'h5A3C_0F1E_2D4B_696;
    logic CORE_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic chip_en = 1'b1;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_kind = 2'h0;
    logic [FRAME_BITS-1:0] cmd_data = 11'h000;
    logic cmd_ready;
    logic [NUM_WORDS*WORD_W-1:0] cfg1, cfg2;
    logic [4:0] st1, st2;
    logic pwr1, pwr2, pecl1, pecl2, lvds1, lvds2;
    int miscompares = 0;
    int tests_run = 0;
    sppc_link_if link();
    sppc_link_if link2();

    always #2 CORE_CLK = ~CORE_CLK;

    sppc_host_end #(.EE_WAIT_CYC(100), .T7_CYC(T7)) sppc_host_end_inst (
        .CORE_CLK(CORE_CLK), .RSTN(RSTN), .LINK(link), .CHIP_EN(chip_en),
        .CMD_VALID(cmd_valid), .CMD_KIND(cmd_kind), .CMD_DATA(cmd_data),
        .CMD_READY(cmd_ready), .RB_WORD(), .RB_DONE());
    sppc_dev_end #(.TMO_CYC(3000)) sppc_dev_end_inst (
        .CORE_CLK(CORE_CLK), .RSTN(RSTN), .LINK(link), .RB_IMAGE(RB_PAT),
        .CFG_WORDS(cfg1), .STATE(st1), .POWER_ON(pwr1), .PECL_EN(pecl1),
        .LVDS_EN(lvds1));
    // Second device takes bits from the bench, which may break the timing
    sppc_dev_end #(.TMO_CYC(3000)) sppc_dev_end_inst2 (
        .CORE_CLK(CORE_CLK), .RSTN(RSTN), .LINK(link2), .RB_IMAGE(RB_PAT),
        .CFG_WORDS(cfg2), .STATE(st2), .POWER_ON(pwr2), .PECL_EN(pecl2),
        .LVDS_EN(lvds2));
    sppc_link_sva #(.T7_CYC(T7)) sppc_link_sva_inst (
        .CORE_CLK(CORE_CLK), .RSTN(RSTN),
        .serial_program_pin(link.serial_program_pin), .ce(link.ce),
        .fout(link.fout));

    // ==========================================================
    // Tasks
    task automatic check(input string what, input logic [63:0] exp,
        input logic [63:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %0h seen %0h", what, exp, got);
            miscompares++;
        end
    endtask

    task automatic test_done();
        if (miscompares == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask

    task automatic wait_ready(output int n);
        n = 0;
        while (cmd_ready !== 1'b1 && n < 60000)
        begin
            idle(1);
            n++;
        end
        if (n >= 60000)
        begin
            miscompares++;
            test_done();
        end
    endtask

    task automatic host_cmd(input logic [1:0] k,
        input logic [FRAME_BITS-1:0] d, input int bits);
        int n;
        wait_ready(n);
        cmd_valid = 1'b1;
        cmd_kind = k;
        cmd_data = d;
        idle(1);
        cmd_valid = 1'b0;
        wait_ready(n);
        check("host cycles", 64'(bits * BIT_CYC), 64'(n));
    endtask

    // Fast bits, period 1900 cycles; still longer than the sample point
    task automatic tx2(input logic [10:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            link2.serial_program_pin = 1'b1;
            idle(v[i] ? 1850 : 50);
            link2.serial_program_pin = 1'b0;
            idle(v[i] ? 50 : 1850);
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic host_side();
        host_cmd(KIND_ENTRY, {5'h00, CODE_PROG}, ENTRY_BITS);
        check("state1", 64'h02, st1);
        host_cmd(KIND_FRAME, {3'h0, 8'h02}, FRAME_BITS);
        check("word0", 64'h02, cfg1[7:0]);
        check("pecl1", 64'h1, pecl1);
        check("lvds1", 64'h0, lvds1);
        host_cmd(KIND_FRAME, {SEL_JUMP, 8'h00}, FRAME_BITS);
        check("state1", 64'h01, st1);
        chip_en = 1'b0;
        idle(8);
        check("power1", 64'h0, pwr1);
        check("pecl1", 64'h0, pecl1);
        check("lvds1", 64'h0, lvds1);
    endtask

    task automatic direct_side();
        tx2(11'h000, 2);
        idle(1500);
        tx2({5'h00, CODE_PROG}, 6);
        check("state2", 64'h02, st2);
        link2.ce = 1'b0;
        idle(10);
        check("power2", 64'h1, pwr2);
        link2.ce = 1'b1;
        tx2(11'h005, 3);
        idle(3200);
        tx2(11'h0A5, 8);
        check("word5", 64'hA5, cfg2[47:40]);
        check("word0", 64'h00, cfg2[7:0]);
        tx2({SEL_JUMP, JMP_FREE}, 11);
        check("state2", 64'h04, st2);
        tx2({SEL_JUMP, 8'h00}, 11);
        check("state2", 64'h01, st2);
        tx2({5'h00, CODE_RB}, 6);
        check("state2", 64'h10, st2);
        for (int k = 0; k < 3; k++)
        begin
            tx2(11'h000, 1);
            check("fout2", {63'h0, RB_PAT[k]}, link2.fout);
        end
    endtask

    initial
    begin
        link2.serial_program_pin = 1'b0;
        link2.ce = 1'b1;
        idle(20);
        RSTN = 1'b1;
        check("state2", 64'h01, st2);
        fork
            host_side();
            direct_side();
        join
        test_done();
    end
endmodule
